// file: rtl/io_alternate_function_select.sv
`timescale 1ns/10ps
module io_alternate_function_select
    import altfn_pkg::*;
#(
    parameter logic [1:0] VARIANT = VARIANT_STANDARD
)(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        soft_reset,
    input  wire logic        reg_wr_en,
    input  wire logic [31:0] reg_wr_data,
    output logic      [31:0] reg_rd_data,
    output logic      [31:0] alt_active,
    input  wire logic [23:0] pin_direction_reg,
    input  wire logic [23:0] output_latch_reg,
    input  wire logic [23:0] pin_pull_config_reg,
    input  wire logic        pwm_enable,
    input  wire logic        flow_control_enable,
    input  wire logic        device_mode_status,
    input  wire logic        tx_active,
    input  wire logic        pwm_wave,
    input  wire logic        rts_level,
    input  wire logic        uart_tx_pending,
    input  wire logic        adc_busy,
    input  wire logic [23:0] pin_in,
    output logic      [23:0] pin_out,
    output logic      [23:0] pin_oe,
    output logic      [23:0] pin_pull_en,
    output logic      [23:0] pin_pull_up,
    output logic      [23:0] pin_level,
    output logic             uart_rxd,
    output logic             uart_cts,
    output logic      [3:0]  analog_en,
    output logic             vref_enable
);

    localparam logic [31:0] IMPL_MASK   = variant_mask(VARIANT);
    localparam logic [31:0] RESET_VALUE = ALT_FACTORY_VALUE & IMPL_MASK;

    logic [31:0]  stored_r;
    logic [31:0]  active_r;
    logic [23:0]  sync1_r;
    logic [23:0]  sync2_r;
    pin_ctrl_type ctrl [NUM_PINS];
    pin_drive_type drive [NUM_PINS];
    logic         uart_rxd_nxt;
    logic         uart_cts_nxt;
    logic [3:0]   analog_en_nxt;
    logic         vref_enable_nxt;

    // ------------------------------------------------------------
    // Stored and active selection
    // ------------------------------------------------------------
    // Reserved bits are dropped on write so they can never select
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stored_r <= RESET_VALUE;
        end else if (reg_wr_en) begin
            stored_r <= reg_wr_data & IMPL_MASK;
        end
    end

    // Writes only reach the pins through a reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            active_r <= RESET_VALUE;
        end else if (soft_reset) begin
            active_r <= stored_r;
        end
    end

    assign reg_rd_data = stored_r;
    assign alt_active  = active_r;

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_level <= '0;
        end else begin
            pin_level <= sync2_r;
        end
    end

    // ------------------------------------------------------------
    // Peripheral routing
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            ctrl[i].alt   = active_r[i];
            ctrl[i].p_out = 1'b0;
            ctrl[i].p_oe  = 1'b0;
            ctrl[i].dir   = pin_direction_reg[i];
            ctrl[i].latch = output_latch_reg[i];
            ctrl[i].pull  = pin_pull_config_reg[i];
        end
        // Status level still needs the direction bit; latch can force high
        ctrl[BIT_MODE_STATUS].p_oe  = pin_direction_reg[BIT_MODE_STATUS];
        ctrl[BIT_MODE_STATUS].p_out = device_mode_status
                                    | output_latch_reg[BIT_MODE_STATUS];
        ctrl[BIT_TX_LOW].p_oe       = 1'b1;
        ctrl[BIT_TX_LOW].p_out      = ~tx_active;
        ctrl[BIT_TX_HIGH].p_oe      = 1'b1;
        ctrl[BIT_TX_HIGH].p_out     = tx_active;
        ctrl[BIT_ANALOG2].p_oe      = pwm_enable;
        ctrl[BIT_ANALOG2].p_out     = pwm_enable & pwm_wave;
        ctrl[BIT_TX_PENDING].p_oe   = 1'b1;
        ctrl[BIT_TX_PENDING].p_out  = uart_tx_pending;
        // Flow control claims the pins regardless of the reserved bits
        if (flow_control_enable) begin
            ctrl[BIT_RTS].alt   = 1'b1;
            ctrl[BIT_RTS].p_oe  = 1'b1;
            ctrl[BIT_RTS].p_out = rts_level;
            ctrl[BIT_CTS].alt   = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            pin_cell u_cell (
                .clock (clock),
                .rstn  (rstn),
                .ctrl  (ctrl[g]),
                .drive (drive[g])
            );
            assign pin_out[g]     = drive[g].out;
            assign pin_oe[g]      = drive[g].oe;
            assign pin_pull_en[g] = drive[g].pull_en;
            assign pin_pull_up[g] = drive[g].pull_up;
        end
    endgenerate

    // ------------------------------------------------------------
    // Peripheral side signals
    // ------------------------------------------------------------
    always_comb begin
        // Receive line idles high when the pin is not routed
        uart_rxd_nxt     = active_r[BIT_RXD] ? sync2_r[BIT_RXD] : 1'b1;
        uart_cts_nxt     = flow_control_enable ? sync2_r[BIT_CTS] : 1'b0;
        analog_en_nxt[3] = active_r[BIT_ANALOG3];
        analog_en_nxt[2] = active_r[BIT_ANALOG2] & ~pwm_enable;
        analog_en_nxt[1] = active_r[BIT_ANALOG1];
        analog_en_nxt[0] = active_r[BIT_ANALOG0];
        // Reference is only worth its current while converting
        vref_enable_nxt  = active_r[BIT_VREF] & adc_busy;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            uart_rxd    <= 1'b1;
            uart_cts    <= 1'b0;
            analog_en   <= '0;
            vref_enable <= 1'b0;
        end else begin
            uart_rxd    <= uart_rxd_nxt;
            uart_cts    <= uart_cts_nxt;
            analog_en   <= analog_en_nxt;
            vref_enable <= vref_enable_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_gpio_dir_follow: assert property (@(posedge clock) disable iff (!rstn)
        !active_r[0] && !pin_pull_config_reg[0] |=>
        pin_oe[0] == $past(pin_direction_reg[0]) && pin_out[0] == $past(output_latch_reg[0]))
        else $error("GPIO pin does not follow direction and latch");

    a_reserved_no_alt: assert property (@(posedge clock) disable iff (!rstn)
        (active_r & ~IMPL_MASK) == 32'h0000_0000)
        else $error("Reserved bit selects an alternate function");

    a_alt_no_pull: assert property (@(posedge clock) disable iff (!rstn)
        active_r[BIT_ANALOG3] |=> !pin_pull_en[BIT_ANALOG3] && !pin_oe[BIT_ANALOG3])
        else $error("Alternate pin still under pull or drive");

    a_mode_status_out: assert property (@(posedge clock) disable iff (!rstn)
        active_r[BIT_MODE_STATUS] && pin_direction_reg[BIT_MODE_STATUS]
        && !output_latch_reg[BIT_MODE_STATUS] |=>
        pin_oe[BIT_MODE_STATUS] && pin_out[BIT_MODE_STATUS] == $past(device_mode_status))
        else $error("Mode status not driven on its pin");

    a_tx_low_out: assert property (@(posedge clock) disable iff (!rstn)
        active_r[BIT_TX_LOW] |=> pin_oe[BIT_TX_LOW] && pin_out[BIT_TX_LOW] == !$past(tx_active))
        else $error("Low transmit activity output wrong");

    a_pwm_takeover: assert property (@(posedge clock) disable iff (!rstn)
        active_r[BIT_ANALOG2] && pwm_enable |=>
        pin_oe[BIT_ANALOG2] && pin_out[BIT_ANALOG2] == $past(pwm_wave) && !analog_en[2])
        else $error("PWM does not take over analog channel two");

    a_rxd_route: assert property (@(posedge clock) disable iff (!rstn)
        active_r[BIT_RXD] |=> uart_rxd == $past(sync2_r[BIT_RXD]))
        else $error("Receive data not routed from its pin");

    a_vref_gate: assert property (@(posedge clock) disable iff (!rstn)
        vref_enable |-> $past(active_r[BIT_VREF]) && $past(adc_busy))
        else $error("Reference driven outside a conversion");

    a_write_deferred: assert property (@(posedge clock) disable iff (!rstn)
        !soft_reset |=> active_r == $past(active_r))
        else $error("Selection changed without a reset");

    a_flow_rts: assert property (@(posedge clock) disable iff (!rstn)
        flow_control_enable |=> pin_oe[BIT_RTS] && pin_out[BIT_RTS] == $past(rts_level))
        else $error("RTS pin not driven under flow control");

    a_tx_pending: assert property (@(posedge clock) disable iff (!rstn)
        active_r[BIT_TX_PENDING] |=> pin_out[BIT_TX_PENDING] == $past(uart_tx_pending))
        else $error("Pending indicator wrong");

endmodule : io_alternate_function_select

// file: rtl/altfn_pkg.sv
// Notes on behaviour
// - Selected pin is owned by its peripheral function.
// - Cleared bit leaves pin as plain GPIO, except PB4/PB3 while flow control is enabled.
// - Bits 23:16 port C, 15:8 B, 7:0 A.
// - Bit 23 puts mode status on port_c_pin_seven if its direction bit is set; latch one forces it high.
// - Bit 22 enables low transmit activity output.
// - Bit 21 enables high transmit activity output.
// - Bit 17 gives PC1 to analog channel three.
// - Bit 15 analog channel two, or PWM out.
// - Bits 14, 13 give PB6, PB5 to analog.
// - Bits 12, 11 reserved; PB4/PB3 flow control.
// - Bit 10 routes port_b_pin_two to UART receive.
// - Bit 9 reference output only during conversion.
// - Bit 7 makes port_a_pin_seven UART pending indicator.
// - Reserved bits select no alternate function.
// - Direction one makes GPIO an output.
package altfn_pkg;

    // ------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------
    localparam int          NUM_PINS          = 24;
    localparam logic [31:0] ALT_FACTORY_VALUE = 32'h0000_0600;
    localparam logic [31:0] MASK_STANDARD     = 32'h00E2_E680;
    localparam logic [31:0] MASK_LONG_RANGE   = 32'h00C2_E480;
    localparam logic [31:0] MASK_EXT_RANGE    = 32'h0082_C480;

    localparam logic [1:0]  VARIANT_STANDARD  = 2'h0;
    localparam logic [1:0]  VARIANT_LONG      = 2'h1;
    localparam logic [1:0]  VARIANT_EXTENDED  = 2'h2;

    // Bit positions; bit index equals pin index
    localparam int BIT_MODE_STATUS = 23;
    localparam int BIT_TX_LOW      = 22;
    localparam int BIT_TX_HIGH     = 21;
    localparam int BIT_ANALOG3     = 17;
    localparam int BIT_ANALOG2     = 15;
    localparam int BIT_ANALOG1     = 14;
    localparam int BIT_ANALOG0     = 13;
    localparam int BIT_RTS         = 12;
    localparam int BIT_CTS         = 11;
    localparam int BIT_RXD         = 10;
    localparam int BIT_VREF        = 9;
    localparam int BIT_TX_PENDING  = 7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic alt;
        logic p_out;
        logic p_oe;
        logic dir;
        logic latch;
        logic pull;
    } pin_ctrl_type;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_en;
        logic pull_up;
    } pin_drive_type;

    function automatic logic [31:0] variant_mask(input logic [1:0] variant);
        unique case (variant)
            VARIANT_LONG:     variant_mask = MASK_LONG_RANGE;
            VARIANT_EXTENDED: variant_mask = MASK_EXT_RANGE;
            default:          variant_mask = MASK_STANDARD;
        endcase
    endfunction : variant_mask

endpackage : altfn_pkg

// file: rtl/pin_cell.sv
`timescale 1ns/10ps
module pin_cell
    import altfn_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire pin_ctrl_type  ctrl,
    output pin_drive_type      drive
);

    pin_drive_type drive_nxt;

    // ------------------------------------------------------------
    // Drive resolution
    // ------------------------------------------------------------
    always_comb begin
        drive_nxt = '0;
        if (ctrl.alt) begin
            // Peripheral overrides direction, latch and pull
            drive_nxt.out = ctrl.p_out;
            drive_nxt.oe  = ctrl.p_oe;
        end else if (ctrl.pull) begin
            if (ctrl.dir) begin
                // Open drain: latch one releases the pin
                drive_nxt.oe = ~ctrl.latch;
            end else begin
                drive_nxt.pull_en = 1'b1;
                drive_nxt.pull_up = ctrl.latch;
            end
        end else begin
            drive_nxt.oe  = ctrl.dir;
            drive_nxt.out = ctrl.latch;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drive <= '0;
        end else begin
            drive <= drive_nxt;
        end
    end

endmodule : pin_cell

// file: test/pin_world.sv
`timescale 1ns/10ps
module pin_world (
    input  wire logic        clock,
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe,
    input  wire logic [23:0] pin_pull_en,
    input  wire logic [23:0] pin_pull_up,
    input  wire logic [23:0] ext_en,
    input  wire logic [23:0] ext_val,
    output logic      [23:0] pin_in
);
    // Floating pins toggle every cycle so a guessed level never matches by luck
    logic [23:0] float_r;
    initial float_r = 24'h5A_5A5A;
    always @(posedge clock) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pull_en[i])
                pin_in[i] = pin_pull_up[i];
            else
                pin_in[i] = float_r[i];
        end
    end
endmodule : pin_world

// file: test/tb_io_alternate_function_select.sv
`timescale 1ns/10ps
module tb_io_alternate_function_select
    import altfn_pkg::*;
    ;
    logic        clock, rstn, soft_reset, reg_wr_en, pwm_enable, flow_control_enable;
    logic        device_mode_status, tx_active, pwm_wave, rts_level, uart_tx_pending;
    logic        adc_busy, uart_rxd, uart_cts, vref_enable;
    logic [31:0] reg_wr_data, reg_rd_data, alt_active;
    logic [23:0] pin_direction_reg, output_latch_reg, pin_pull_config_reg, pin_in;
    logic [23:0] pin_out, pin_oe, pin_pull_en, pin_pull_up, pin_level, ext_en, ext_val;
    logic [3:0]  analog_en;
    int          failures, tests_run, cycles;

    io_alternate_function_select dut_u (
        .clock               (clock),
        .rstn                (rstn),
        .soft_reset          (soft_reset),
        .reg_wr_en           (reg_wr_en),
        .reg_wr_data         (reg_wr_data),
        .reg_rd_data         (reg_rd_data),
        .alt_active          (alt_active),
        .pin_direction_reg   (pin_direction_reg),
        .output_latch_reg    (output_latch_reg),
        .pin_pull_config_reg (pin_pull_config_reg),
        .pwm_enable          (pwm_enable),
        .flow_control_enable (flow_control_enable),
        .device_mode_status  (device_mode_status),
        .tx_active           (tx_active),
        .pwm_wave            (pwm_wave),
        .rts_level           (rts_level),
        .uart_tx_pending     (uart_tx_pending),
        .adc_busy            (adc_busy),
        .pin_in              (pin_in),
        .pin_out             (pin_out),
        .pin_oe              (pin_oe),
        .pin_pull_en         (pin_pull_en),
        .pin_pull_up         (pin_pull_up),
        .pin_level           (pin_level),
        .uart_rxd            (uart_rxd),
        .uart_cts            (uart_cts),
        .analog_en           (analog_en),
        .vref_enable         (vref_enable)
    );

    pin_world world_u (
        .clock       (clock),
        .pin_out     (pin_out),
        .pin_oe      (pin_oe),
        .pin_pull_en (pin_pull_en),
        .pin_pull_up (pin_pull_up),
        .ext_en      (ext_en),
        .ext_val     (ext_val),
        .pin_in      (pin_in)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask : settle

    task automatic wr(input logic [31:0] d);
        reg_wr_en   = 1'b1;
        reg_wr_data = d;
        settle(1);
        reg_wr_en   = 1'b0;
        settle(1);
    endtask : wr

    // The stored word only reaches the pins through a reset
    task automatic apply();
        soft_reset = 1'b1;
        settle(1);
        soft_reset = 1'b0;
        settle(3);
    endtask : apply

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_factory();
        check(reg_rd_data, 32'h0000_0600);
        check(alt_active, 32'h0000_0600);
        ext_en = 24'h00_0400;
        ext_val = 24'h00_0000;
        settle(5);
        check(uart_rxd, 1'b0);
        check(pin_oe[10], 1'b0);
        ext_val = 24'h00_0400;
        adc_busy = 1'b1;
        settle(5);
        check(uart_rxd, 1'b1);
        check(vref_enable, 1'b1);
        adc_busy = 1'b0;
        settle(2);
        check(vref_enable, 1'b0);
    endtask : t_factory

    task automatic t_store();
        wr(32'h0000_0001);
        check(reg_rd_data, 32'h0000_0000);
        wr(32'hFFFF_FFFF);
        check(reg_rd_data, MASK_STANDARD);
        check(alt_active, 32'h0000_0600);
        apply();
        check(alt_active, MASK_STANDARD);
    endtask : t_store

    task automatic t_periph();
        pin_direction_reg = 24'hFF_FFFF;
        device_mode_status = 1'b1;
        tx_active = 1'b1;
        uart_tx_pending = 1'b1;
        settle(3);
        check(pin_oe, 24'hFD_19FF);
        check(pin_out & pin_oe, 24'hA0_0080);
        check(analog_en, 4'hF);
        device_mode_status = 1'b0;
        tx_active = 1'b0;
        settle(3);
        check(pin_out & pin_oe, 24'h40_0080);
        output_latch_reg = 24'h80_0000;
        pwm_enable = 1'b1;
        pwm_wave = 1'b1;
        settle(3);
        check(pin_out[23], 1'b1);
        check({pin_oe[15], pin_out[15]}, 2'h3);
        check(analog_en, 4'hB);
        pwm_enable = 1'b0;
        output_latch_reg = 24'h00_0000;
    endtask : t_periph

    task automatic t_gpio();
        wr(32'h0000_0000);
        apply();
        ext_en = 24'h00_0000;
        pin_direction_reg = 24'h00_00FF;
        output_latch_reg = 24'h00_F00F;
        pin_pull_config_reg = 24'h00_FF00;
        adc_busy = 1'b1;
        settle(6);
        check(pin_oe, 24'h00_00FF);
        check(pin_out & pin_oe, 24'h00_000F);
        check(pin_pull_en, 24'h00_FF00);
        check(pin_level[15:0], 16'hF00F);
        check({uart_rxd, vref_enable, analog_en}, 6'h20);
        check(uart_cts, 1'b0);
        // Pulled pins with direction set become open drain
        pin_direction_reg = 24'h00_0F00;
        settle(3);
        check(pin_oe, 24'h00_0F00);
        check(pin_out, 24'h00_000F);
        check(pin_pull_en, 24'h00_F000);
        check(pin_pull_up, 24'h00_F000);
    endtask : t_gpio

    task automatic t_flow();
        flow_control_enable = 1'b1;
        rts_level = 1'b1;
        pin_direction_reg = 24'h00_0000;
        ext_en = 24'h00_0800;
        ext_val = 24'h00_0800;
        settle(5);
        check({pin_oe[12], pin_out[12], pin_oe[11]}, 3'h6);
        check(uart_cts, 1'b1);
    endtask : t_flow

    // ------------------------------------------------------------
    // Clock, reset and sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        {rstn, soft_reset, reg_wr_en, pwm_enable, flow_control_enable} = 5'h0;
        {device_mode_status, tx_active, pwm_wave, rts_level, uart_tx_pending} = 5'h0;
        adc_busy = 1'b0;
        reg_wr_data = 32'h0000_0000;
        {pin_direction_reg, output_latch_reg, pin_pull_config_reg} = 72'h0;
        {ext_en, ext_val} = 48'h0;
        settle(16);
        rstn = 1'b1;
        settle(2);
        t_factory();
        t_store();
        t_periph();
        t_gpio();
        t_flow();
        finish_test();
    end
endmodule : tb_io_alternate_function_select
